// ===== rtl/smc_top.sv
// Main control register of a frequency synthesizer with calibration start.
// Assumes a host on the plain register port and a chip-enable pin.
//
// What this block and its host do
// RULE1 - Soft-reset bit restores all configuration defaults
// RULE2 - Soft-reset bit clears itself after reset
// RULE3 - Sleep bit powers the device down
// RULE4 - Chip-enable low also powers device down
// RULE5 - Host rewrites control with calibration after wake
// RULE6 - Host waits 100 us before rewriting
// RULE7 - Recal bit toggle recalibrates both profiles
// RULE8 - Host clears recal bit after use
// RULE9 - Init-cal bit calibrates both at first programming
// RULE10 - Without init-cal only one profile calibrated
// RULE11 - Host leaves init-cal zero without switching
// RULE12 - Profile-select bit picks active register set
// RULE13 - Host writes zeros to bits 15-14
// RULE14 - Host writes zero to bits 11,10,8
// RULE15 - Host writes one into field 5-1
// RULE16 - Calibration enable makes write start calibration
// RULE17 - Write with enable clear starts nothing
// RULE18 - Control at offset zero, resets to 0x3
// RULE19 - Actions start after the write is accepted
`timescale 1ns/1ps
module smc_top
    import smc_pkg::*;
(
    input wire logic ref_clk, // 10 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic [ADDR_W-1:0] addr, // Register address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [DATA_W-1:0] rdata, // Read data, cycle after strobe
    input wire logic ce_pin, // Chip enable pin, low powers down
    output logic power_down, // Device powered down
    output logic profile_select, // 0 first profile, 1 second
    output logic cfg_reset, // One-cycle reset to config registers
    output logic cal_busy, // Calibration running
    output logic cal_target // Profile under calibration
);

    smc_top_st_t st_r;
    smc_top_st_t st_nxt;
    smc_cal_if cal_link ();

    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by reads and writes
    function automatic logic smc_hit(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off);
        smc_hit = (a == off);
    endfunction : smc_hit

    ////////////////////////////////////////////////////////////////////////
    // Calibration sequencer
    smc_cal u_cal (
        .ref_clk (ref_clk),
        .nrst (nrst),
        .cal (cal_link.eng)
    );

    assign cal_link.start = st_r.cal_start;
    assign cal_link.both = st_r.cal_both;
    assign cal_link.sel = st_r.cal_sel;
    assign cal_link.abort = st_r.pd | st_r.srst;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic wr_ctrl;
        logic rd_ctrl;
        logic rd_stat;
        logic pd_now;
        wr_ctrl = 1'b0;
        rd_ctrl = 1'b0;
        rd_stat = 1'b0;
        pd_now = 1'b0;

        st_nxt = st_r;
        st_nxt.cal_start = 1'b0;
        st_nxt.rdata = DATA_ZERO;

        wr_ctrl = wr_en && smc_hit(addr, ADDR_MAIN_CONTROL); // [RULE18]
        rd_ctrl = rd_en && smc_hit(addr, ADDR_MAIN_CONTROL);
        rd_stat = rd_en && smc_hit(addr, ADDR_CAL_STATUS);

        // Chip-enable pin: change taken when second and third stage agree
        st_nxt.ce_sync = {st_r.ce_sync[1:0], ce_pin};
        if (st_r.ce_sync[1] == st_r.ce_sync[2])
        begin
            st_nxt.ce_lvl = st_r.ce_sync[1];
        end

        // Power-down follows the stored bit or the pin, a cycle after the write
        pd_now = st_r.ctrl[BIT_SLEEP_REQUEST] | ~st_r.ce_lvl; // [RULE3] [RULE4] [RULE19]
        st_nxt.pd = pd_now;

        // Calibration results are lost on wake and on soft reset
        if ((st_r.pd && !pd_now) || st_r.srst)
        begin
            st_nxt.cal_ok = 2'b00;
        end
        if (cal_link.done)
        begin
            st_nxt.cal_ok[cal_link.done_prof] = 1'b1;
        end

        if (st_r.srst)
        begin
            // Reset wins over a write in the same cycle
            st_nxt.ctrl = MAIN_CONTROL_RST; // [RULE1] [RULE2]
            st_nxt.srst = 1'b0; // [RULE2]
        end
        else if (wr_ctrl)
        begin
            st_nxt.ctrl = wdata;
            st_nxt.srst = wdata[BIT_SOFT_RESET]; // [RULE1] [RULE19]
            st_nxt.first_done = 1'b1;
            // Start only when enabled; a reset request overrides it
            st_nxt.cal_start = wdata[BIT_CALIB_ENABLE] &&
                !wdata[BIT_SOFT_RESET]; // [RULE16] [RULE17] [RULE19]
            st_nxt.cal_both = (!st_r.first_done &&
                wdata[BIT_DUAL_PROFILE_INIT_CAL]) || // [RULE9]
                (wdata[BIT_DUAL_PROFILE_RECAL] &&
                !st_r.ctrl[BIT_DUAL_PROFILE_RECAL]); // [RULE7]
            st_nxt.cal_sel = wdata[BIT_PROFILE_SELECT]; // [RULE10]
        end

        // Read data stands only in the cycle after the strobe
        if (rd_ctrl)
        begin
            st_nxt.rdata = st_r.ctrl;
        end
        else if (rd_stat)
        begin
            st_nxt.rdata[BIT_ST_FIRST_DONE] = st_r.first_done;
            st_nxt.rdata[BIT_ST_CAL_OK_A] = st_r.cal_ok[0];
            st_nxt.rdata[BIT_ST_CAL_OK_B] = st_r.cal_ok[1];
            st_nxt.rdata[BIT_ST_POWER_DOWN] = st_r.pd;
            st_nxt.rdata[BIT_ST_CAL_BUSY] = cal_link.busy;
            st_nxt.rdata[BIT_ST_CAL_TARGET] = cal_link.target;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.ctrl <= MAIN_CONTROL_RST; // [RULE18]
            st_r.ce_sync <= 3'h7;
            st_r.ce_lvl <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata = st_r.rdata;
    assign power_down = st_r.pd;
    assign profile_select = st_r.ctrl[BIT_PROFILE_SELECT]; // [RULE12]
    assign cfg_reset = st_r.srst; // [RULE1]
    assign cal_busy = cal_link.busy;
    assign cal_target = cal_link.target;

endmodule : smc_top

// ===== pkg/smc_pkg.sv
// Constants and types for the synthesizer main control register block.
// Assumes a 10 MHz ref_clk and a 16-bit register port.
package smc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_MAIN_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CAL_STATUS = 4'h1;
    localparam logic [DATA_W-1:0] MAIN_CONTROL_RST = 16'h0003;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // main_control fields
    localparam int unsigned BIT_SOFT_RESET = 13;
    localparam int unsigned BIT_SLEEP_REQUEST = 12;
    localparam int unsigned BIT_DUAL_PROFILE_RECAL = 9;
    localparam int unsigned BIT_DUAL_PROFILE_INIT_CAL = 7;
    localparam int unsigned BIT_PROFILE_SELECT = 6;
    localparam int unsigned BIT_CALIB_ENABLE = 0;

    ////////////////////////////////////////////////////////////////////////
    // cal_status fields
    localparam int unsigned BIT_ST_FIRST_DONE = 0;
    localparam int unsigned BIT_ST_CAL_OK_A = 1;
    localparam int unsigned BIT_ST_CAL_OK_B = 2;
    localparam int unsigned BIT_ST_POWER_DOWN = 3;
    localparam int unsigned BIT_ST_CAL_BUSY = 4;
    localparam int unsigned BIT_ST_CAL_TARGET = 5;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CAL_TIME_NS = 20000;
    localparam int unsigned CAL_CYC_INT = (CAL_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        CAL_TIME_NS / CLK_PERIOD_NS;
    localparam logic [15:0] CAL_CYC = 16'(CAL_CYC_INT);
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam int unsigned SLEEP_EXIT_WAIT_US = 100;
    localparam int unsigned SLEEP_EXIT_WAIT_CYC = SLEEP_EXIT_WAIT_US * 1000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic {SMC_CAL_IDLE, SMC_CAL_RUN} smc_cal_state_t;

    typedef struct packed {
        smc_cal_state_t state;
        logic [15:0] cnt;
        logic prof;
        logic pend_b;
        logic busy;
        logic done;
        logic done_prof;
    } smc_cal_st_t;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [2:0] ce_sync;
        logic ce_lvl;
        logic pd;
        logic srst;
        logic [DATA_W-1:0] rdata;
        logic first_done;
        logic [1:0] cal_ok;
        logic cal_start;
        logic cal_both;
        logic cal_sel;
    } smc_top_st_t;

endpackage : smc_pkg

// ===== pkg/smc_cal_if.sv
// Link between the control register and its calibration sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface smc_cal_if;
    logic start;
    logic both;
    logic sel;
    logic abort;
    logic busy;
    logic done;
    logic done_prof;
    logic target;

    modport ctrl (output start, output both, output sel, output abort,
        input busy, input done, input done_prof, input target);
    modport eng (input start, input both, input sel, input abort,
        output busy, output done, output done_prof, output target);
endinterface : smc_cal_if

// ===== rtl/smc_cal.sv
// Calibration sequencer: runs one or both profile calibrations.
// Assumes start is a one-clock flag from the control register; abort is held high while powered down.
`timescale 1ns/1ps
module smc_cal
    import smc_pkg::*;
(
    input wire logic ref_clk, // 10 MHz clock
    input wire logic nrst, // Async reset, active low
    smc_cal_if.eng cal // Request and result link
);

    smc_cal_st_t st_r;
    smc_cal_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (cal.abort)
        begin
            st_nxt.state = SMC_CAL_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.pend_b = 1'b0;
        end
        else if (cal.start)
        begin
            // A new request restarts any calibration in progress
            st_nxt.state = SMC_CAL_RUN;
            st_nxt.busy = 1'b1;
            st_nxt.cnt = CAL_CYC - CNT_ONE;
            st_nxt.prof = cal.both ? 1'b0 : cal.sel; // [RULE10]
            st_nxt.pend_b = cal.both; // [RULE7] [RULE9]
        end
        else
        begin
            unique case (st_r.state)
                SMC_CAL_IDLE:
                begin
                    st_nxt.busy = 1'b0;
                end
                SMC_CAL_RUN:
                begin
                    if (st_r.cnt == CNT_ZERO)
                    begin
                        st_nxt.done = 1'b1;
                        st_nxt.done_prof = st_r.prof;
                        if (st_r.pend_b)
                        begin
                            st_nxt.prof = 1'b1;
                            st_nxt.pend_b = 1'b0;
                            st_nxt.cnt = CAL_CYC - CNT_ONE;
                        end
                        else
                        begin
                            st_nxt.state = SMC_CAL_IDLE;
                            st_nxt.busy = 1'b0;
                        end
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt - CNT_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign cal.busy = st_r.busy;
    assign cal.done = st_r.done;
    assign cal.done_prof = st_r.done_prof;
    assign cal.target = st_r.prof;

endmodule : smc_cal

// ===== tb/smc_top_monitor.sv
// Checker for the synthesizer main control register block.
// Assumes the smc_top port list and one clock domain.
`timescale 1ns/1ps
module smc_top_chk
    import smc_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic [ADDR_W-1:0] addr, // Address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire logic [DATA_W-1:0] rdata, // Read data
    input wire logic ce_pin, // Chip enable
    input wire logic power_down, // Powered down
    input wire logic profile_select, // Active profile
    input wire logic cfg_reset, // Config reset pulse
    input wire logic cal_busy, // Calibration running
    input wire logic cal_target // Profile being calibrated
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    logic wr0;
    logic wr_rst;
    logic wr_sleep;
    logic wr_run;
    logic wr_nocal;
    logic sel_bit;
    assign wr_rst = wr_en && addr == ADDR_MAIN_CONTROL && wdata[BIT_SOFT_RESET];
    assign wr0 = wr_en && addr == ADDR_MAIN_CONTROL && !cfg_reset && !wdata[BIT_SOFT_RESET];
    assign wr_sleep = wr0 && wdata[BIT_SLEEP_REQUEST];
    assign wr_run = wr0 && wdata[BIT_CALIB_ENABLE] && !wdata[BIT_SLEEP_REQUEST];
    assign wr_nocal = wr0 && !wdata[BIT_CALIB_ENABLE] && !cal_busy;
    assign sel_bit = wdata[BIT_PROFILE_SELECT];
    ////////////////////////////////////////////////////////////////////////
    sr_pulse_a: assert property (cfg_reset |=> !cfg_reset)
        else $error("cfg_reset longer than one cycle");
    sr_start_a: assert property (wr_rst && !cfg_reset |=> cfg_reset)
        else $error("soft reset write gave no cfg_reset");
    sleep_set_a: assert property (wr_sleep |=> ##1 power_down)
        else $error("sleep write did not power down");
    prof_sel_a: assert property (wr0 |=> profile_select == $past(sel_bit))
        else $error("profile_select does not follow the write");
    cal_go_a: assert property (wr_run && !power_down |=> ##1 cal_busy)
        else $error("calibration did not start");
    cal_none_a: assert property (wr_nocal && !$past(wr_en) |=> !cal_busy [*2])
        else $error("calibration started with enable clear");
    ce_sleep_a: assert property ($fell(ce_pin) |-> ##[2:6] power_down)
        else $error("chip enable low did not power down");
    rd_quiet_a: assert property (!$past(rd_en) |-> rdata == DATA_ZERO)
        else $error("read data outside its cycle");
endmodule : smc_top_chk

bind smc_top smc_top_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ce_pin(ce_pin), .power_down(power_down),
    .profile_select(profile_select), .cfg_reset(cfg_reset), .cal_busy(cal_busy),
    .cal_target(cal_target));

// ===== tb/smc_host_bfm.sv
// Host model that programs the main control register over the plain port.
// Assumes requests are launched just after a rising edge.
`timescale 1ns/1ps
module smc_host_bfm
    import smc_pkg::*;
(
    input wire logic ref_clk, // Clock
    output logic [ADDR_W-1:0] addr, // Address
    output logic [DATA_W-1:0] wdata, // Write data
    output logic wr_en, // Write strobe
    output logic rd_en, // Read strobe
    input wire logic [DATA_W-1:0] rdata // Read data
);
    initial
    begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    // Reserved bits of main_control always go out as zero, field 5-1 as one
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= (a == ADDR_MAIN_CONTROL) ? ((d & 16'h32C1) | 16'h0002) : d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        d = rdata;
    endtask : rd
endmodule : smc_host_bfm

// ===== tb/test_synth_main_control_register.sv
// Testbench for the synthesizer main control register block.
// Assumes a 10 MHz clock and 200-cycle calibration per profile.
`timescale 1ns/1ps
module test_synth_main_control_register
    import smc_pkg::*;
;
    logic ref_clk, nrst, ce_pin, wr_en, rd_en, mid_t;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv;
    logic power_down, profile_select, cfg_reset, cal_busy, cal_target;
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    smc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ce_pin(ce_pin), .power_down(power_down),
        .profile_select(profile_select), .cfg_reset(cfg_reset), .cal_busy(cal_busy),
        .cal_target(cal_target));
    smc_host_bfm host_u (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Expected cal_status word, busy always clear when read
    function automatic logic [15:0] st_word(logic fd, logic ok_a, logic ok_b, logic pd, logic tg);
        logic [15:0] w;
        w = DATA_ZERO;
        w[BIT_ST_FIRST_DONE] = fd;
        w[BIT_ST_CAL_OK_A] = ok_a;
        w[BIT_ST_CAL_OK_B] = ok_b;
        w[BIT_ST_POWER_DOWN] = pd;
        w[BIT_ST_CAL_TARGET] = tg;
        return w;
    endfunction : st_word
    task close_out;
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Write with calibration, then time the busy span and note the late target
    task cal_go(logic [15:0] d, int lo, int hi, logic t0, logic t);
        host_u.wr(ADDR_MAIN_CONTROL, d);
        @(posedge ref_clk);
        #1;
        chk("cal_start", 16'h0001, cal_busy);
        chk("cal_first", t0, cal_target);
        mid_t = cal_target;
        n = 1;
        while (cal_busy === 1'b1 && n < 1000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n == 300)
                mid_t = cal_target;
        end
        chk("cal_len", 16'h0001, (n >= lo && n <= hi));
        chk("cal_target", t, mid_t);
    endtask : cal_go
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        host_u.rd(ADDR_MAIN_CONTROL, rv);
        chk("main_control", MAIN_CONTROL_RST, rv);
        host_u.rd(4'hF, rv);
        chk("unmapped", DATA_ZERO, rv);
    endtask : t_regs
    task t_cal;
        cal_go(16'h0083, 395, 410, 1'b0, 1'b1);
        host_u.wr(ADDR_MAIN_CONTROL, 16'h0042);
        @(posedge ref_clk);
        #1;
        chk("select", 16'h0001, profile_select);
        chk("no_cal", 16'h0000, cal_busy);
        cal_go(16'h0043, 195, 205, 1'b1, 1'b1);
        cal_go(16'h0243, 395, 410, 1'b0, 1'b1);
        cal_go(16'h0003, 195, 205, 1'b0, 1'b0);
        host_u.rd(ADDR_CAL_STATUS, rv);
        chk("status_cal", st_word(1'b1, 1'b1, 1'b1, 1'b0, 1'b0), rv);
    endtask : t_cal
    task t_power;
        host_u.wr(ADDR_MAIN_CONTROL, 16'h1042);
        @(posedge ref_clk);
        #1;
        chk("sleep", 16'h0001, power_down);
        host_u.wr(ADDR_MAIN_CONTROL, 16'h0042);
        @(posedge ref_clk);
        #1;
        chk("wake", 16'h0000, power_down);
        @(posedge ref_clk);
        ce_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("ce_low", 16'h0001, power_down);
        host_u.rd(ADDR_CAL_STATUS, rv);
        chk("status_pd", st_word(1'b1, 1'b0, 1'b0, 1'b1, 1'b0), rv);
        @(posedge ref_clk);
        ce_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("ce_high", 16'h0000, power_down);
        repeat (SLEEP_EXIT_WAIT_CYC) @(posedge ref_clk);
        cal_go(16'h0043, 195, 205, 1'b1, 1'b1);
        host_u.rd(ADDR_CAL_STATUS, rv);
        chk("status_wake", st_word(1'b1, 1'b0, 1'b1, 1'b0, 1'b1), rv);
    endtask : t_power
    task t_soft;
        host_u.wr(ADDR_MAIN_CONTROL, 16'h2043);
        #1;
        chk("cfg_reset", 16'h0001, cfg_reset);
        @(posedge ref_clk);
        #1;
        chk("self_clear", 16'h0000, cfg_reset);
        host_u.rd(ADDR_MAIN_CONTROL, rv);
        chk("after_reset", MAIN_CONTROL_RST, rv);
        chk("sel_default", 16'h0000, profile_select);
    endtask : t_soft
    // Hardware reset while idle re-arms first programming; init-cal off gives one profile
    task t_rearm;
        @(posedge ref_clk);
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        host_u.rd(ADDR_CAL_STATUS, rv);
        chk("status_rst", DATA_ZERO, rv);
        cal_go(16'h0043, 195, 205, 1'b1, 1'b1);
    endtask : t_rearm
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ce_pin = 1'b1;
        nrst = 1'b0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs;
        t_cal;
        t_power;
        t_soft;
        t_rearm;
        close_out;
    end
    initial
    begin
        #3000000;
        bad_count++;
        close_out;
    end
endmodule : test_synth_main_control_register
